/* verilog/idw_regs.svh */
// Identify words 86-126: offsets, field positions, reset values, fixed words
// Assumes 32-bit APB data with one aligned word per register
`ifndef IDW_REGS_SVH
`define IDW_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define IDW_OFF_UDMA      8'h00
`define IDW_OFF_ERASE     8'h04
`define IDW_OFF_MPW       8'h08
`define IDW_OFF_RST       8'h0c
`define IDW_OFF_WSEL      8'h10
`define IDW_OFF_WDATA     8'h14
// ****************************************
// Field positions
// ****************************************
`define IDW_UDMA_EN_BIT   3
`define IDW_ERASE_ENH_LSB 16
// ****************************************
// Reset values
// ****************************************
`define IDW_RST_UDMA      4'h0
`define IDW_RST_ERASE     16'h0000
`define IDW_RST_MPW       16'h0000
`define IDW_RST_RSTRES    9'h000
`define IDW_RST_WSEL      8'h56
// ****************************************
// Word indices and fixed contents
// ****************************************
`define IDW_W86           8'h56
`define IDW_W87           8'h57
`define IDW_W88           8'h58
`define IDW_W89           8'h59
`define IDW_W90           8'h5a
`define IDW_W91           8'h5b
`define IDW_W92           8'h5c
`define IDW_W93           8'h5d
`define IDW_W94           8'h5e
`define IDW_W126          8'h7e
`define IDW_VAL86         16'h1808
`define IDW_VAL87         16'h4003
`define IDW_UDMA_SUPP     8'h3f
`define IDW_JUMPER        2'h1
`endif

/* verilog/idw_pkg.sv */
// Types for the identify-word block
// Assumes the constants header is included by its users
package idw_pkg;
    // Reset-result inputs held by software
    typedef struct packed {
        logic       d1_pdiag;   // Device 1 asserted PDIAG-
        logic       diag_pass;
        logic       pdiag_seen;
        logic       dasp_seen;
        logic       resp_sel1;
        logic [1:0] num_method;
        logic       cblid_high;
        logic       is_dev1;
    } idw_rstres_t;

    // Whole block state
    typedef struct packed {
        logic [3:0]  udma;      // [3] valid, [2:0] selected mode
        logic [15:0] erase_norm;
        logic [15:0] erase_enh;
        logic [15:0] mpw_rev;
        idw_rstres_t rstres;
        logic [7:0]  wsel;
        logic [31:0] prdata;
        logic [15:0] id_data;
        logic        id_valid;
    } idw_state_t;
endpackage : idw_pkg

/* verilog/idw_words.sv */
// Identify-data words 86..126 with APB configuration registers
// Assumes a synchronous host read port and an APB master on pclk
//
// Operation
// - Word 86 reads 1808h
// - Word 87 reads 4003h
// - Word 88 low byte 3Fh, bits 7-6 zero
// - Word 88 bits 13-8 one-hot selected mode 0-5, zero when not valid or mode 6-7
// - Word 89 normal erase time, two minutes/count
// - Word 90 enhanced erase time, zero unspecified
// - Word 92 stored master password revision
// - Word 93 bit 13 cable-detect level
// - Numbering method codes in 10-9, 2-1
// - First device reset results in low byte
// - Second device fills 12-8, low byte 01h
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "idw_regs.svh"

module idw_words (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Identify word read port
    input  wire logic        id_req,
    input  wire logic [7:0]  id_idx,
    output logic      [15:0] id_data,
    output logic             id_valid
);

    idw_pkg::idw_state_t s_q;
    idw_pkg::idw_state_t s_d;
    logic                wr_acc;
    logic                setup;

    // ****************************************
    // Word assembly
    // ****************************************
    // Shared by the host port and the APB window register
    function automatic logic [15:0] idw_word(input logic [7:0] idx, input idw_pkg::idw_state_t s);
        logic [15:0] w;
        logic [5:0]  sel;
        w   = 16'h0000;
        sel = 6'h00;
        if (s.udma[`IDW_UDMA_EN_BIT] && s.udma[2:0] < 3'h6)
        begin
            sel = 6'(6'h01 << s.udma[2:0]);
        end
        case (idx)
            `IDW_W86: w = `IDW_VAL86;
            `IDW_W87: w = `IDW_VAL87;
            `IDW_W88: w = {2'h0, sel, `IDW_UDMA_SUPP};
            `IDW_W89: w = s.erase_norm;
            `IDW_W90: w = s.erase_enh;
            `IDW_W92: w = s.mpw_rev;
            `IDW_W93:
            begin
                w[15:14] = 2'h1;
                w[13]    = s.rstres.cblid_high;
                w[0]     = 1'b1;
                if (s.rstres.is_dev1)
                begin
                    // Low byte stays cleared apart from bit 0
                    w[12:8] = {1'b0, s.rstres.d1_pdiag, s.rstres.num_method, 1'b1};
                end
                else
                begin
                    w[6] = s.rstres.resp_sel1;
                    w[5] = s.rstres.dasp_seen;
                    w[4] = s.rstres.pdiag_seen;
                    w[3] = s.rstres.diag_pass;
                    w[2:1] = s.rstres.num_method;
                end
            end
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : idw_word

    // ****************************************
    // APB decode
    // ****************************************
    function automatic logic idw_mapped(input logic [7:0] a);
        return a == `IDW_OFF_UDMA || a == `IDW_OFF_ERASE || a == `IDW_OFF_MPW ||
               a == `IDW_OFF_RST  || a == `IDW_OFF_WSEL  || a == `IDW_OFF_WDATA;
    endfunction : idw_mapped

    // Zero wait states; read data is caught in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !idw_mapped(paddr);
    assign wr_acc  = psel && penable && pwrite && idw_mapped(paddr);
    assign setup   = psel && !penable;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s_d          = s_q;
        s_d.id_valid = id_req;
        if (id_req)
        begin
            s_d.id_data = idw_word(id_idx, s_q);
        end
        if (setup && !pwrite)
        begin
            case (paddr)
                `IDW_OFF_UDMA:  s_d.prdata = {28'h0, s_q.udma};
                `IDW_OFF_ERASE: s_d.prdata = {s_q.erase_enh, s_q.erase_norm};
                `IDW_OFF_MPW:   s_d.prdata = {16'h0, s_q.mpw_rev};
                `IDW_OFF_RST:   s_d.prdata = {23'h0, s_q.rstres};
                `IDW_OFF_WSEL:  s_d.prdata = {24'h0, s_q.wsel};
                `IDW_OFF_WDATA: s_d.prdata = {16'h0, idw_word(s_q.wsel, s_q)};
                default:        s_d.prdata = 32'h0000_0000;
            endcase
        end
        if (wr_acc)
        begin
            case (paddr)
                `IDW_OFF_UDMA:  s_d.udma = pwdata[3:0];
                `IDW_OFF_ERASE:
                begin
                    s_d.erase_norm = pwdata[15:0];
                    s_d.erase_enh  = pwdata[`IDW_ERASE_ENH_LSB +: 16];
                end
                `IDW_OFF_MPW:   s_d.mpw_rev = pwdata[15:0];
                `IDW_OFF_RST:   s_d.rstres  = pwdata[8:0];
                `IDW_OFF_WSEL:  s_d.wsel    = pwdata[7:0];
                default:        s_d.wsel    = s_q.wsel;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q.udma       <= `IDW_RST_UDMA;
            s_q.erase_norm <= `IDW_RST_ERASE;
            s_q.erase_enh  <= `IDW_RST_ERASE;
            s_q.mpw_rev    <= `IDW_RST_MPW;
            s_q.rstres     <= `IDW_RST_RSTRES;
            s_q.wsel       <= `IDW_RST_WSEL;
            s_q.prdata     <= 32'h0000_0000;
            s_q.id_data    <= 16'h0000;
            s_q.id_valid   <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata   = s_q.prdata;
    assign id_data  = s_q.id_data;
    assign id_valid = s_q.id_valid;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_word86_fixed: assert property (id_req && id_idx == `IDW_W86 |=> id_valid && id_data == 16'h1808)
        else $error("word 86 not 1808h");

    a_word87_fixed: assert property (id_req && id_idx == `IDW_W87 |=> id_data == 16'h4003)
        else $error("word 87 not 4003h");

    a_udma_support: assert property (id_req && id_idx == `IDW_W88 |=> id_data[7:0] == 8'h3f)
        else $error("word 88 low byte wrong");

    a_udma_select: assert property (id_req && id_idx == `IDW_W88 |=>
        $onehot0(id_data[13:8]) && id_data[15:14] == 2'h0 &&
        (id_data[13:8] != 6'h00) == ($past(s_q.udma[3]) && $past(s_q.udma[2:0]) < 3'h6))
        else $error("word 88 selection bits wrong");

    a_erase_norm: assert property (wr_acc && paddr == `IDW_OFF_ERASE ##2 id_req && id_idx == `IDW_W89
        |=> id_data == $past(pwdata[15:0], 3))
        else $error("word 89 not the written count");

    a_erase_enh: assert property (id_req && id_idx == `IDW_W90 |=> id_data == $past(s_q.erase_enh))
        else $error("word 90 mismatch");

    a_mpw_rev: assert property (wr_acc && paddr == `IDW_OFF_MPW ##2 id_req && id_idx == `IDW_W92
        |=> id_data == $past(pwdata[15:0], 3))
        else $error("word 92 not last stored revision");

    a_cable_bit: assert property (id_req && id_idx == `IDW_W93 |=>
        id_data[15:13] == {2'h1, $past(s_q.rstres.cblid_high)})
        else $error("word 93 cable bit wrong");

    a_dev1_result: assert property (id_req && id_idx == `IDW_W93 && s_q.rstres.is_dev1 |=>
        id_data[7:0] == 8'h01 && id_data[12] == 1'b0 && id_data[8] == 1'b1 &&
        id_data[10:9] == $past(s_q.rstres.num_method))
        else $error("word 93 device 1 fields wrong");

    a_dev0_result: assert property (id_req && id_idx == `IDW_W93 && !s_q.rstres.is_dev1 |=>
        id_data[12:7] == 6'h00 && id_data[0] &&
        id_data[6:1] == {$past(s_q.rstres.resp_sel1), $past(s_q.rstres.dasp_seen),
                         $past(s_q.rstres.pdiag_seen), $past(s_q.rstres.diag_pass),
                         $past(s_q.rstres.num_method)})
        else $error("word 93 device 0 fields wrong");

    a_reserved_zero: assert property (id_req && id_idx >= `IDW_W94 && id_idx <= `IDW_W126
        |=> id_valid && id_data == 16'h0000)
        else $error("reserved word not zero");

    a_apb_unmapped: assert property (psel && !penable && !pwrite && !idw_mapped(paddr) |=>
        prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // ****************************************
    // Host port checks
    // ****************************************

    a_valid_rise: assert property (id_req |=>
        id_valid)
        else $error("no valid after request");

    a_valid_fall: assert property (!id_req |=>
        !id_valid)
        else $error("valid without request");

    a_data_hold: assert property (!id_req |=>
        $stable(id_data))
        else $error("identify data changed without request");

    a_word91_zero: assert property (id_req && id_idx == `IDW_W91 |=>
        id_data == 16'h0000)
        else $error("word 91 not zero");

    a_below_range: assert property (id_req && id_idx < `IDW_W86 |=>
        id_data == 16'h0000)
        else $error("word below range not zero");

    a_above_range: assert property (id_req && id_idx > `IDW_W126 |=>
        id_data == 16'h0000)
        else $error("word above range not zero");

    a_udma_reserved: assert property (id_req && id_idx == `IDW_W88 |=>
        id_data[15:14] == 2'h0 && id_data[7:6] == 2'h0)
        else $error("word 88 reserved bits set");

    a_udma_mode_bit: assert property (id_req && id_idx == `IDW_W88 && s_q.udma[3] && s_q.udma[2:0] < 3'h6
        |=> id_data[13:8] == 6'h01 << $past(s_q.udma[2:0]))
        else $error("word 88 wrong mode bit");

    a_udma_invalid: assert property (id_req && id_idx == `IDW_W88 && !s_q.udma[3] |=>
        id_data[13:8] == 6'h00)
        else $error("word 88 mode shown while not valid");

    a_dev1_pdiag: assert property (id_req && id_idx == `IDW_W93 && s_q.rstres.is_dev1 |=>
        id_data[11] == $past(s_q.rstres.d1_pdiag))
        else $error("word 93 device 1 diag bit wrong");

    a_word93_fixed: assert property (id_req && id_idx == `IDW_W93 |=>
        id_data[15:14] == 2'h1 && id_data[0] == 1'b1)
        else $error("word 93 fixed bits wrong");

    a_enh_unspec: assert property (wr_acc && paddr == `IDW_OFF_ERASE && pwdata[31:16] == 16'h0000
        ##2 id_req && id_idx == `IDW_W90 |=> id_data == 16'h0000)
        else $error("word 90 not zero when unspecified");

    a_erase_enh_wr: assert property (wr_acc && paddr == `IDW_OFF_ERASE ##2 id_req && id_idx == `IDW_W90
        |=> id_data == $past(pwdata[31:16], 3))
        else $error("word 90 not the written count");

    // ****************************************
    // Register bus checks
    // ****************************************

    a_pready_high: assert property (pready)
        else $error("ready low");

    a_slverr_phase: assert property (pslverr |->
        psel && penable)
        else $error("error outside access phase");

    a_slverr_unmapped: assert property (psel && penable && !idw_mapped(paddr) |->
        pslverr)
        else $error("no error for unmapped access");

    a_no_err_mapped: assert property (psel && penable && idw_mapped(paddr) |->
        !pslverr)
        else $error("error for mapped access");

    a_unmapped_nowrite: assert property (psel && penable && pwrite && !idw_mapped(paddr) |=>
        $stable(s_q.udma) && $stable(s_q.erase_norm) && $stable(s_q.erase_enh) &&
        $stable(s_q.mpw_rev) && $stable(s_q.rstres) && $stable(s_q.wsel))
        else $error("unmapped write changed a register");

    a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=>
        $stable(prdata))
        else $error("read data changed outside read setup");

    a_udma_upper: assert property (psel && !penable && !pwrite && paddr == `IDW_OFF_UDMA |=>
        prdata[31:4] == 28'h0)
        else $error("mode register upper bits set");

    a_mpw_upper: assert property (psel && !penable && !pwrite && paddr == `IDW_OFF_MPW |=>
        prdata[31:16] == 16'h0)
        else $error("revision register upper bits set");

    a_rst_upper: assert property (psel && !penable && !pwrite && paddr == `IDW_OFF_RST |=>
        prdata[31:9] == 23'h0)
        else $error("reset result register upper bits set");

    a_wsel_upper: assert property (psel && !penable && !pwrite && paddr == `IDW_OFF_WSEL |=>
        prdata[31:8] == 24'h0)
        else $error("window select upper bits set");

    a_window_upper: assert property (psel && !penable && !pwrite && paddr == `IDW_OFF_WDATA |=>
        prdata[31:16] == 16'h0)
        else $error("window upper bits set");

    a_window_w86: assert property (psel && !penable && !pwrite && paddr == `IDW_OFF_WDATA &&
        s_q.wsel == `IDW_W86 |=> prdata == 32'h0000_1808)
        else $error("window word 86 wrong");

    a_mpw_hold: assert property (!(wr_acc && paddr == `IDW_OFF_MPW) |=>
        $stable(s_q.mpw_rev))
        else $error("revision changed without write");

    a_erase_hold: assert property (!(wr_acc && paddr == `IDW_OFF_ERASE) |=>
        $stable(s_q.erase_norm) && $stable(s_q.erase_enh))
        else $error("erase counts changed without write");

    a_wsel_hold: assert property (!(wr_acc && paddr == `IDW_OFF_WSEL) |=>
        $stable(s_q.wsel))
        else $error("window select changed without write");

    a_udma_hold: assert property (!(wr_acc && paddr == `IDW_OFF_UDMA) |=>
        $stable(s_q.udma))
        else $error("mode register changed without write");

    a_rst_hold: assert property (!(wr_acc && paddr == `IDW_OFF_RST) |=>
        $stable(s_q.rstres))
        else $error("reset result changed without write");

endmodule : idw_words

/* dv/idw_host.sv */
// Host-side model that reads identify words from the block
// Assumes the block answers one cycle after the request edge
`timescale 1ns/1ps

module idw_host (
    // Clock
    input  wire logic        pclk,
    // Identify word port
    output logic             id_req,
    output logic      [7:0]  id_idx,
    input  wire logic [15:0] id_data,
    input  wire logic        id_valid
);
    initial
    begin
        id_req = 1'b0;
        id_idx = 8'h00;
    end

    // Ok low when the word reads 0000h or FFFFh
    task automatic read(input logic [7:0] idx, output logic [15:0] d, output logic ok);
        @(posedge pclk);
        id_req <= 1'b1;
        id_idx <= idx;
        @(posedge pclk);
        id_req <= 1'b0;
        // Released index never keeps its last value
        id_idx <= ~idx;
        do
            @(posedge pclk);
        while (id_valid !== 1'b1);
        d  = id_data;
        ok = (d !== 16'h0000) && (d !== 16'hffff);
    endtask : read
endmodule : idw_host

/* dv/tb.sv */
// Self-checking bench for the identify-word block
// Assumes design, package and constants header are compiled first
`timescale 1ns/1ps
`include "idw_regs.svh"

module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        id_req, id_valid, err, ok;
    logic [7:0]  paddr, id_idx;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] id_data, w;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc        = 0;

    idw_words uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                   .id_req(id_req), .id_idx(id_idx), .id_data(id_data), .id_valid(id_valid));
    idw_host host (.pclk(pclk), .id_req(id_req), .id_idx(id_idx), .id_data(id_data), .id_valid(id_valid));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic word(input logic [7:0] i, input logic [15:0] e);
        host.read(i, w, ok);
        chk($sformatf("word %0d", i), {16'h0000, e}, {16'h0000, w});
    endtask : word

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_fixed();
        apb(1'b0, `IDW_OFF_WDATA, 32'h0);
        chk("window after reset", 32'h1808, rd);
        word(8'd86, 16'h1808);
        chk("notify ok", 32'h1, {31'h0, ok});
        word(8'd87, 16'h4003);
        word(8'd88, 16'h003f);
        word(8'd85, 16'h0000);
        word(8'd91, 16'h0000);
        word(8'd127, 16'h0000);
        for (int i = 94; i <= 126; i++)
            word(i[7:0], 16'h0000);
    endtask : t_fixed

    task automatic t_udma();
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, `IDW_OFF_UDMA, {28'h0, 1'b1, m[2:0]});
            word(8'd88, 16'h003f | ((m < 6) ? (16'h0100 << m) : 16'h0000));
        end
        apb(1'b1, `IDW_OFF_UDMA, 32'h5);
        word(8'd88, 16'h003f);
    endtask : t_udma

    task automatic t_erase();
        apb(1'b1, `IDW_OFF_ERASE, 32'h0012_0034);
        word(8'd89, 16'h0034);
        word(8'd90, 16'h0012);
        apb(1'b1, `IDW_OFF_ERASE, 32'h0000_ffff);
        word(8'd90, 16'h0000);
        word(8'd89, 16'hffff);
        apb(1'b1, `IDW_OFF_MPW, 32'h0000_abcd);
        word(8'd92, 16'habcd);
    endtask : t_erase

    // Device 0 then device 1, with device 0 fields set to show they are dropped
    task automatic t_reset_word();
        apb(1'b1, `IDW_OFF_RST, 32'h0d6);
        word(8'd93, 16'h605b);
        apb(1'b1, `IDW_OFF_RST, 32'h1f9);
        word(8'd93, 16'h4d01);
        apb(1'b1, `IDW_OFF_WSEL, 32'h5d);
        apb(1'b0, `IDW_OFF_WDATA, 32'h0);
        chk("window word 93", 32'h4d01, rd);
    endtask : t_reset_word

    task automatic t_unmapped();
        apb(1'b1, 8'h20, 32'hffff_ffff);
        chk("write error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h20, 32'h0);
        chk("read error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask : t_unmapped

    // Register readback after the reset-word scenario
    task automatic t_readback();
        apb(1'b0, `IDW_OFF_UDMA, 32'h0);
        chk("udma reg", 32'h5, rd);
        apb(1'b0, `IDW_OFF_ERASE, 32'h0);
        chk("erase reg", 32'h0000_ffff, rd);
        apb(1'b0, `IDW_OFF_MPW, 32'h0);
        chk("mpw reg", 32'h0000_abcd, rd);
        apb(1'b0, `IDW_OFF_RST, 32'h0);
        chk("reset result reg", 32'h1f9, rd);
        apb(1'b0, `IDW_OFF_WSEL, 32'h0);
        chk("window select reg", 32'h5d, rd);
        chk("mapped error", 32'h0, {31'h0, err});
    endtask : t_readback

    // Reset in mid-run must bring back the documented defaults
    task automatic t_midreset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `IDW_OFF_WDATA, 32'h0);
        chk("window after mid reset", 32'h1808, rd);
        word(8'd89, 16'h0000);
        word(8'd88, 16'h003f);
        word(8'd92, 16'h0000);
    endtask : t_midreset

    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_fixed();
        t_udma();
        t_erase();
        t_reset_word();
        t_readback();
        t_unmapped();
        t_midreset();
        end_of_test();
    end
endmodule : tb
